// ===== rsw_pkg.sv
package rsw_pkg;

  // ==========================================================
  // Timing in half oscillator periods
  // ==========================================================
  localparam logic [10:0] HOP_LONG_MIN   = 11'h408;  // Long pulse when above this
  localparam logic [10:0] HOP_SHORT_MIN  = 11'h004;  // Short pulse when above this
  localparam logic [10:0] HOP_PULSE_SAT  = 11'h409;  // Saturation of pulse count
  localparam logic [10:0] HOP_DETECT     = 11'h00c;  // Hold cancel and abort phase
  localparam logic [10:0] HOP_SEQ        = 11'h400;  // Internal sequence length
  localparam logic [10:0] HOP_LATCH_FAST = 11'h006;  // Latch delay, bypass with prescaler
  localparam logic [10:0] HOP_LATCH_SLOW = 11'h008;  // Latch delay otherwise

  // ==========================================================
  // Register word indexes (byte address = index * 4)
  // ==========================================================
  localparam logic [2:0] REG_SYSCFG  = 3'h0;
  localparam logic [2:0] REG_WDCTL   = 3'h1;
  localparam logic [2:0] REG_CMD     = 3'h2;
  localparam logic [2:0] REG_STATUS  = 3'h3;
  localparam logic [2:0] REG_WDCOUNT = 3'h4;
  localparam logic [2:0] REG_CONFIG  = 3'h5;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned SYSCFG_BDR_BIT  = 5;
  localparam int unsigned WDCTL_PRESC_BIT = 0;
  localparam int unsigned WDCTL_REL_LSB   = 8;
  localparam int unsigned CMD_SOFT_BIT    = 0;
  localparam int unsigned CMD_END_OF_INIT_INSTR_BIT   = 1;
  localparam int unsigned CMD_SERVICE_BIT = 2;
  localparam int unsigned CMD_WDDIS_BIT   = 3;
  localparam int unsigned STAT_WDEN_BIT   = 3;
  localparam int unsigned STAT_INIT_BIT   = 4;
  localparam int unsigned STAT_ROUT_BIT   = 5;
  localparam int unsigned STAT_ST_LSB     = 8;

  // ==========================================================
  // Values
  // ==========================================================
  localparam logic [23:0] RESTART_ADDR   = 24'h000000;
  localparam logic [15:0] CFG_RESET      = 16'hffff;  // Port pins pulled high
  localparam logic [15:0] CFG_SOFT_LATCH = 16'h1f00;  // Bits 12..8 relatched
  localparam logic [15:0] CFG_SOFT_KEEP  = 16'he003;  // Bits 7..2 cleared
  localparam logic [7:0]  WD_RELOAD_RST  = 8'h00;
  localparam logic [6:0]  WD_DIV_LO_M1   = 7'h01;     // Divide by 2
  localparam logic [6:0]  WD_DIV_HI_M1   = 7'h7f;     // Divide by 128

  typedef enum logic [2:0] {
    ST_RUN       = 3'b000,
    ST_DETECT    = 3'b001,
    ST_SEQ       = 3'b011,
    ST_WAIT_HIGH = 3'b010,
    ST_LATCH     = 3'b110
  } rsw_state_e;

  typedef enum logic [2:0] {
    CAUSE_POWER_ON = 3'h0,
    CAUSE_LONG_HW  = 3'h1,
    CAUSE_SHORT_HW = 3'h2,
    CAUSE_WATCHDOG = 3'h3,
    CAUSE_SOFTWARE = 3'h4
  } rsw_cause_e;

endpackage

// ===== rsw_reset_sequencer.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Low pulse over 1032 half periods is long; over 4 up to 1032 short.
// - Reset pin low with async select low forces asynchronous reset at once.
// - Async reset: reset out low, abort, tristate, config pulled high, then wait for reset pin high.
// - Async reset detection is combinational, needs no running clock.
// - On release: latch config, strobes idle, restart at address zero.
// - Latch 6 half periods after release if bypass with prescaler, else 8.
// - Reset pin low with async select high starts a warm reset.
// - Warm reset: tristate, reset out low, 12 half periods cancel and abort.
// - Pin pulldown during reset only if enable bit 5 set; cleared after.
// - Sequence runs 1024 half periods, then waits for reset pin high.
// - Async select falling during warm reset switches to async reset only while the reset pin is still low.
// - Software reset runs the warm sequence; relatch 12..8, clear 7..2.
// - Watchdog on after reset; disable works only before end of init.
// - Watchdog overflow starts internal reset and pulls reset out low.
// - Watchdog is 16 bits, clock divided by 2 or by 128.
// - Each service reloads the counter high byte from the reload value.
// - Reset out stays low until end of init, then goes high.
// - Watchdog reset end: relatch config 12..8, clear 7..2.
module rsw_reset_sequencer #(
  parameter int unsigned HOP_DIV = 1  // Clocks per half oscillator period
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reset_in_n_i,
  output logic             reset_in_n_o,
  output logic             reset_in_n_oe_n_o,
  input  wire logic        async_sel_i,
  input  wire logic [15:0] config_port_i,
  input  wire logic        pll_bypass_presc_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             reset_out_n_o,
  output logic             core_reset_o,
  output logic             hold_cancel_o,
  output logic             bus_abort_o,
  output logic             io_tristate_o,
  output logic             config_pullup_o,
  output logic             strobes_idle_o,
  output logic             restart_o,
  output logic [23:0]      restart_addr_o,
  output logic [15:0]      config_latched_o
);

  // ==========================================================
  // Asynchronous reset path
  // ==========================================================
  logic arst_n;
  // Pins gate the reset directly, no clock involved
  assign arst_n = rst_n_i & (reset_in_n_i | async_sel_i);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [2:0]  pin_meta_r;
  logic [2:0]  pin_sync_r;
  logic [15:0] cfg_meta_r;
  logic [15:0] cfg_sync_r;
  logic        rin_s;
  logic        asel_s;
  logic        bypass_s;

  // Two stages before any logic except the async reset path looks at the pins or the config port
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 3'b011;  // Idle pin levels, no false edge after reset
      pin_sync_r <= 3'b011;
      cfg_meta_r <= rsw_pkg::CFG_RESET;
      cfg_sync_r <= rsw_pkg::CFG_RESET;
    end else begin
      pin_meta_r <= {pll_bypass_presc_i, async_sel_i, reset_in_n_i};
      pin_sync_r <= pin_meta_r;
      cfg_meta_r <= config_port_i;
      cfg_sync_r <= cfg_meta_r;
    end
  end
  assign rin_s    = pin_sync_r[0];
  assign asel_s   = pin_sync_r[1];
  assign bypass_s = pin_sync_r[2];

  // ==========================================================
  // Half oscillator period tick
  // ==========================================================
  logic [15:0] hop_div_r;
  logic        hop_tick;
  assign hop_tick = (hop_div_r == 16'(HOP_DIV - 1));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hop_div_r <= 16'h0000;
    end else begin
      hop_div_r <= hop_tick ? 16'h0000 : hop_div_r + 16'h0001;
    end
  end

  // ==========================================================
  // Pulse measurement and cause
  // ==========================================================
  logic [10:0]         pulse_cnt_r;
  logic                rin_prev_r;
  rsw_pkg::rsw_cause_e cause_r;
  logic                rin_rise;
  assign rin_rise = rin_s & ~rin_prev_r;

  // Counts low time in half periods, survives the async reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_cnt_r <= 11'h000;
      rin_prev_r  <= 1'b1;
    end else begin
      rin_prev_r <= rin_s;
      if (rin_s) begin
        pulse_cnt_r <= 11'h000;
      end else if (hop_tick && pulse_cnt_r != rsw_pkg::HOP_PULSE_SAT) begin
        pulse_cnt_r <= pulse_cnt_r + 11'h001;
      end
    end
  end

  // ==========================================================
  // Sequencer state machine
  // ==========================================================
  rsw_pkg::rsw_state_e state_r;
  logic [10:0]         seq_cnt_r;
  logic                partial_r;
  logic                bdr_active_r;
  logic                soft_req;
  logic                wd_ovf;
  logic                warm_req;
  logic                int_req;
  logic [10:0]         latch_delay;

  assign warm_req    = ~rin_s & asel_s & (pulse_cnt_r > rsw_pkg::HOP_SHORT_MIN);
  assign int_req     = soft_req | wd_ovf;
  assign latch_delay = bypass_s ? rsw_pkg::HOP_LATCH_FAST : rsw_pkg::HOP_LATCH_SLOW;

  logic bdr_en_r;

  // Warm, software and watchdog resets share one sequence
  always_ff @(posedge ref_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= rsw_pkg::ST_WAIT_HIGH;
      seq_cnt_r    <= 11'h000;
      partial_r    <= 1'b0;
      bdr_active_r <= 1'b0;
    end else begin
      unique case (state_r)
        rsw_pkg::ST_RUN: begin
          seq_cnt_r <= 11'h000;
          if (warm_req || int_req) begin
            state_r      <= rsw_pkg::ST_DETECT;
            partial_r    <= ~warm_req;
            bdr_active_r <= bdr_en_r;
          end
        end
        rsw_pkg::ST_DETECT: begin
          if (hop_tick) begin
            if (seq_cnt_r == rsw_pkg::HOP_DETECT - 11'h001) begin
              seq_cnt_r <= 11'h000;
              state_r   <= rsw_pkg::ST_SEQ;
            end else begin
              seq_cnt_r <= seq_cnt_r + 11'h001;
            end
          end
        end
        rsw_pkg::ST_SEQ: begin
          if (hop_tick) begin
            if (seq_cnt_r == rsw_pkg::HOP_SEQ - 11'h001) begin
              seq_cnt_r    <= 11'h000;
              bdr_active_r <= 1'b0;
              state_r      <= rsw_pkg::ST_WAIT_HIGH;
            end else begin
              seq_cnt_r <= seq_cnt_r + 11'h001;
            end
          end
        end
        rsw_pkg::ST_WAIT_HIGH: begin
          seq_cnt_r <= 11'h000;
          if (rin_s) begin
            state_r <= rsw_pkg::ST_LATCH;
          end
        end
        rsw_pkg::ST_LATCH: begin
          if (!rin_s) begin
            state_r <= rsw_pkg::ST_WAIT_HIGH;
          end else if (hop_tick) begin
            if (seq_cnt_r == latch_delay - 11'h001) begin
              state_r <= rsw_pkg::ST_RUN;
            end else begin
              seq_cnt_r <= seq_cnt_r + 11'h001;
            end
          end
        end
        default: begin
          state_r <= rsw_pkg::ST_WAIT_HIGH;
        end
      endcase
    end
  end

  logic seq_done;
  assign seq_done = (state_r == rsw_pkg::ST_LATCH) & rin_s & hop_tick
                  & (seq_cnt_r == latch_delay - 11'h001);

  // Reset cause follows classification and sequence entry
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_r <= rsw_pkg::CAUSE_POWER_ON;
    end else if (!rin_s && !asel_s) begin
      cause_r <= rsw_pkg::CAUSE_LONG_HW;
    end else if (rin_rise && pulse_cnt_r > rsw_pkg::HOP_LONG_MIN) begin
      cause_r <= rsw_pkg::CAUSE_LONG_HW;
    end else if (state_r == rsw_pkg::ST_RUN && warm_req) begin
      cause_r <= rsw_pkg::CAUSE_SHORT_HW;  // Upgraded at release if long
    end else if (state_r == rsw_pkg::ST_RUN && wd_ovf) begin
      cause_r <= rsw_pkg::CAUSE_WATCHDOG;
    end else if (state_r == rsw_pkg::ST_RUN && soft_req) begin
      cause_r <= rsw_pkg::CAUSE_SOFTWARE;
    end
  end

  // ==========================================================
  // Reset side effects
  // ==========================================================
  logic in_reset_r;
  logic abort_r;
  logic rout_n_r;
  logic init_done_r;
  logic restart_r;
  logic end_of_init_instr_req;

  // Forced at once by the async reset, released by the sequence; reset out only by end of init
  always_ff @(posedge ref_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      in_reset_r <= 1'b1;
      abort_r    <= 1'b1;
      rout_n_r   <= 1'b0;
      restart_r  <= 1'b0;
    end else begin
      in_reset_r <= (state_r != rsw_pkg::ST_RUN) | warm_req | int_req;
      abort_r    <= (state_r == rsw_pkg::ST_DETECT) | warm_req | int_req;
      restart_r  <= seq_done;
      if (warm_req || int_req || state_r != rsw_pkg::ST_RUN) begin
        rout_n_r <= 1'b0;
      end else if (end_of_init_instr_req) begin
        rout_n_r <= 1'b1;
      end
    end
  end

  // End of init flag, cleared by every reset
  always_ff @(posedge ref_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      init_done_r <= 1'b0;
    end else if (state_r != rsw_pkg::ST_RUN) begin
      init_done_r <= 1'b0;
    end else if (end_of_init_instr_req) begin
      init_done_r <= 1'b1;
    end
  end

  // Configuration latch at sequence end
  always_ff @(posedge ref_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      config_latched_o <= rsw_pkg::CFG_RESET;
      restart_addr_o   <= rsw_pkg::RESTART_ADDR;
    end else if (seq_done) begin
      restart_addr_o <= rsw_pkg::RESTART_ADDR;
      if (partial_r) begin
        config_latched_o <= (cfg_sync_r & rsw_pkg::CFG_SOFT_LATCH)
                          | (config_latched_o & rsw_pkg::CFG_SOFT_KEEP);
      end else begin
        config_latched_o <= cfg_sync_r;
      end
    end
  end

  assign core_reset_o      = in_reset_r;
  assign io_tristate_o     = in_reset_r;
  assign config_pullup_o   = in_reset_r;
  assign strobes_idle_o    = in_reset_r;
  assign hold_cancel_o     = abort_r;
  assign bus_abort_o       = abort_r;
  assign reset_out_n_o     = rout_n_r;
  assign restart_o         = restart_r;
  assign reset_in_n_o      = 1'b0;
  // Pulldown only when enabled at entry, dropped before the wait for high
  assign reset_in_n_oe_n_o = ~(bdr_active_r &
                               ((state_r == rsw_pkg::ST_DETECT) |
                                (state_r == rsw_pkg::ST_SEQ)));

  // ==========================================================
  // Watchdog
  // ==========================================================
  logic [15:0] wd_cnt_r;
  logic [6:0]  wd_presc_r;
  logic        wd_en_r;
  logic [7:0]  wd_reload_r;
  logic        wd_sel_r;
  logic        wd_service;
  logic        wd_disable;
  logic        wd_step;

  assign wd_step = ((wd_presc_r & (wd_sel_r ? rsw_pkg::WD_DIV_HI_M1 : rsw_pkg::WD_DIV_LO_M1))
                   == (wd_sel_r ? rsw_pkg::WD_DIV_HI_M1 : rsw_pkg::WD_DIV_LO_M1));
  assign wd_ovf  = wd_en_r & wd_step & (wd_cnt_r == 16'hffff) & (state_r == rsw_pkg::ST_RUN);

  // Counter cleared and held at zero while the sequence runs
  always_ff @(posedge ref_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_r   <= 16'h0000;
      wd_presc_r <= 7'h00;
      wd_en_r    <= 1'b1;
    end else if (state_r != rsw_pkg::ST_RUN) begin
      wd_cnt_r   <= 16'h0000;
      wd_presc_r <= 7'h00;
      wd_en_r    <= 1'b1;
    end else begin
      wd_presc_r <= wd_presc_r + 7'h01;
      if (wd_disable && !init_done_r) begin
        wd_en_r <= 1'b0;
      end
      if (wd_service) begin
        wd_cnt_r <= {wd_reload_r, 8'h00};
      end else if (wd_en_r && wd_step) begin
        wd_cnt_r <= wd_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Avalon-MM slave
  // ==========================================================
  logic        ack_r;
  logic        wr_go;
  logic [2:0]  widx;
  logic [31:0] rd_mux;

  assign widx              = avs_address_i[4:2];
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign wr_go             = avs_write_i & ack_r;
  assign soft_req   = wr_go & avs_byteenable_i[0] & (widx == rsw_pkg::REG_CMD)
                    & avs_writedata_i[rsw_pkg::CMD_SOFT_BIT];
  assign end_of_init_instr_req  = wr_go & avs_byteenable_i[0] & (widx == rsw_pkg::REG_CMD)
                    & avs_writedata_i[rsw_pkg::CMD_END_OF_INIT_INSTR_BIT];
  assign wd_service = wr_go & avs_byteenable_i[0] & (widx == rsw_pkg::REG_CMD)
                    & avs_writedata_i[rsw_pkg::CMD_SERVICE_BIT];
  assign wd_disable = wr_go & avs_byteenable_i[0] & (widx == rsw_pkg::REG_CMD)
                    & avs_writedata_i[rsw_pkg::CMD_WDDIS_BIT];

  // One wait cycle per access
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
    end
  end

  // Writable configuration, enable bit cleared by every sequence
  always_ff @(posedge ref_clk_i or negedge arst_n) begin
    if (!arst_n) begin
      bdr_en_r    <= 1'b0;
      wd_reload_r <= rsw_pkg::WD_RELOAD_RST;
      wd_sel_r    <= 1'b0;
    end else if (state_r != rsw_pkg::ST_RUN) begin
      bdr_en_r <= 1'b0;
    end else if (wr_go) begin
      if (widx == rsw_pkg::REG_SYSCFG && avs_byteenable_i[0]) begin
        bdr_en_r <= avs_writedata_i[rsw_pkg::SYSCFG_BDR_BIT];
      end
      if (widx == rsw_pkg::REG_WDCTL && avs_byteenable_i[0]) begin
        wd_sel_r <= avs_writedata_i[rsw_pkg::WDCTL_PRESC_BIT];
      end
      if (widx == rsw_pkg::REG_WDCTL && avs_byteenable_i[1]) begin
        wd_reload_r <= avs_writedata_i[rsw_pkg::WDCTL_REL_LSB +: 8];
      end
    end
  end

  // Read decode, unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (widx)
      rsw_pkg::REG_SYSCFG:  rd_mux[rsw_pkg::SYSCFG_BDR_BIT] = bdr_en_r;
      rsw_pkg::REG_WDCTL: begin
        rd_mux[rsw_pkg::WDCTL_PRESC_BIT]     = wd_sel_r;
        rd_mux[rsw_pkg::WDCTL_REL_LSB +: 8] = wd_reload_r;
      end
      rsw_pkg::REG_STATUS: begin
        rd_mux[2:0]                        = cause_r;
        rd_mux[rsw_pkg::STAT_WDEN_BIT]     = wd_en_r;
        rd_mux[rsw_pkg::STAT_INIT_BIT]     = init_done_r;
        rd_mux[rsw_pkg::STAT_ROUT_BIT]     = rout_n_r;
        rd_mux[rsw_pkg::STAT_ST_LSB +: 3] = state_r;
      end
      rsw_pkg::REG_WDCOUNT: rd_mux[15:0] = wd_cnt_r;
      rsw_pkg::REG_CONFIG:  rd_mux[15:0] = config_latched_o;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= rd_mux;
    end
  end

endmodule // rsw_reset_sequencer

`default_nettype wire

// ===== rsw_reset_sequencer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_reset_sequencer_monitor #(
  parameter int unsigned HOP_DIV = 1
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        reset_in_n_i,
  input wire logic        async_sel_i,
  input wire logic        avs_write_i,
  input wire logic        reset_in_n_o,
  input wire logic        reset_in_n_oe_n_o,
  input wire logic        reset_out_n_o,
  input wire logic        core_reset_o,
  input wire logic        hold_cancel_o,
  input wire logic        io_tristate_o,
  input wire logic        config_pullup_o,
  input wire logic        restart_o,
  input wire logic [23:0] restart_addr_o
);
  // =====
  // Reset sequence properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_async;
    !reset_in_n_i && !async_sel_i |-> core_reset_o && !reset_out_n_o;
  endproperty
  a_async: assert property (p_async) else $error("async reset not taken");
  property p_rout_low;
    core_reset_o |-> !reset_out_n_o;
  endproperty
  a_rout_low: assert property (p_rout_low) else $error("reset out high in reset");
  property p_tristate;
    !reset_in_n_i && !async_sel_i |-> io_tristate_o && config_pullup_o && hold_cancel_o;
  endproperty
  a_tristate: assert property (p_tristate) else $error("pins not released");
  property p_pulldown;
    !reset_in_n_oe_n_o |-> core_reset_o && (reset_in_n_o == 1'b0);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown outside reset");
  property p_restart_addr;
    restart_o |-> restart_addr_o == 24'h000000 ##1 !restart_o;
  endproperty
  a_restart_addr: assert property (p_restart_addr) else $error("bad restart");
  property p_latch;
    restart_o |-> $past(reset_in_n_i, 8);
  endproperty
  a_latch: assert property (p_latch) else $error("restart with pin low");
  property p_cancel_len;
    $fell(hold_cancel_o) |-> $past(hold_cancel_o, 12);
  endproperty
  a_cancel_len: assert property (p_cancel_len) else $error("cancel phase short");
  property p_rout_release;
    $rose(reset_out_n_o) |-> ($past(avs_write_i) || $past(avs_write_i, 2)) && !core_reset_o;
  endproperty
  a_rout_release: assert property (p_rout_release) else $error("early release");
  c_restart: cover property (restart_o);
  c_pulldown: cover property (!reset_in_n_oe_n_o);
  c_release: cover property ($rose(reset_out_n_o));
endmodule // rsw_reset_sequencer_monitor
`default_nettype wire

// ===== rsw_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsw_board_model #(
  parameter int unsigned PWR_HOLD = 40  // Cycles until clock and port settle
) (
  input  wire logic        ref_clk_i,
  input  wire logic        pd_oe_n_i,
  input  wire logic        vpp_drop_i,
  input  wire logic [11:0] press_len_i,
  input  wire logic        press_go_i,
  output logic             pin_o,
  output logic             async_sel_o
);
  int unsigned pwr_cnt = 0;
  int unsigned press_cnt = 0;
  // =====
  // Power-up hold of both pins
  always_ff @(posedge ref_clk_i) begin
    if (pwr_cnt < PWR_HOLD) begin
      pwr_cnt <= pwr_cnt + 1;
    end
  end
  // Manual press, never under 5 half periods
  always_ff @(posedge ref_clk_i) begin
    if (press_go_i) begin
      press_cnt <= (press_len_i < 12'h005) ? 5 : 32'(press_len_i);
    end else if (press_cnt != 0) begin
      press_cnt <= press_cnt - 1;
    end
  end
  // Pull-up wins unless someone pulls low
  assign pin_o = !(pwr_cnt < PWR_HOLD || press_cnt != 0 || !pd_oe_n_i);
  assign async_sel_o = !(pwr_cnt < PWR_HOLD || vpp_drop_i);
endmodule // rsw_board_model
`default_nettype wire

// ===== tb_rsw_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rsw_reset_sequencer;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reset_in_n_i, async_sel_i, pll_bypass_presc_i = 1'b0;
  logic reset_in_n_o, reset_in_n_oe_n_o, avs_waitrequest_o, reset_out_n_o, core_reset_o;
  logic hold_cancel_o, bus_abort_o, io_tristate_o, config_pullup_o, strobes_idle_o, restart_o;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0, vpp = 1'b0, go = 1'b0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [4:0]  avs_address_i = 5'h00;
  logic [11:0] plen = 12'h000;
  logic [15:0] config_port_i = 16'h5a3c, config_latched_o;
  logic [23:0] restart_addr_o;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdv;
  int n_fail = 0, cmp_count = 0, since_rise = 0, nr, nk, n8;
  rsw_reset_sequencer #(.HOP_DIV(1)) DUT (.*);
  rsw_board_model u_board (.ref_clk_i, .pd_oe_n_i(reset_in_n_oe_n_o), .vpp_drop_i(vpp),
    .press_len_i(plen), .press_go_i(go), .pin_o(reset_in_n_i), .async_sel_o(async_sel_i));
  // =====
  // Clock and pin-high counter
  always #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) since_rise <= reset_in_n_i ? since_rise + 1 : 0;
  // =====
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    rdv = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    nk = 0;
    do begin
      @(posedge ref_clk_i);
      nk++;
    end while (s !== 1'b1 && nk < lim);
    nr = since_rise;
    if (nk >= lim) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic press(input logic [11:0] n);
    @(posedge ref_clk_i);
    plen <= n;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
  endtask
  // =====
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk(core_reset_o, 1);
    wait_hi(restart_o, 3000);
    chk(config_latched_o, 16'h5a3c);
    chk(restart_addr_o, 0);
    bus(0, 5'h0c, 0);
    chk(rdv[5:0], 6'h09);
    bus(1, 5'h08, 32'h8);
    bus(0, 5'h0c, 0);
    chk(rdv[3], 0);
    bus(1, 5'h08, 32'h2);
    bus(0, 5'h0c, 0);
    chk(rdv[5:4], 2'b11);
    config_port_i <= 16'hc3a5;
    bus(1, 5'h00, 32'h20);
    press(8);
    for (int i = 0; i < 40 && reset_in_n_oe_n_o !== 1'b0; i++) @(posedge ref_clk_i);
    chk(reset_in_n_oe_n_o, 0);
    chk(bus_abort_o, 1);
    chk(strobes_idle_o, 1);
    wait_hi(restart_o, 3000);
    chk(config_latched_o, 16'hc3a5);
    bus(0, 5'h00, 0);
    chk(rdv[5], 0);
    bus(0, 5'h0c, 0);
    chk(rdv[3:0], 4'h9);
    press(8);
    wait_hi(restart_o, 3000);
    bus(0, 5'h0c, 0);
    chk(rdv[2:0], 2);
    press(1100);
    wait_hi(restart_o, 3000);
    n8 = nr;
    bus(0, 5'h0c, 0);
    chk(rdv[2:0], 1);
    pll_bypass_presc_i <= 1'b1;
    press(1100);
    wait_hi(restart_o, 3000);
    chk(n8 - nr, 2);
    press(1000);
    repeat (100) @(posedge ref_clk_i);
    vpp <= 1'b1;
    @(posedge ref_clk_i);
    chk(config_latched_o, rsw_pkg::CFG_RESET);
    vpp <= 1'b0;
    wait_hi(restart_o, 3000);
    config_port_i <= 16'h0ff0;
    bus(1, 5'h08, 32'h1);
    wait_hi(restart_o, 3000);
    chk(config_latched_o, 16'hc3a5 & rsw_pkg::CFG_SOFT_KEEP | 16'h0f00);
    for (int s = 0; s < 2; s++) begin
      bus(1, 5'h08, 32'h2);
      bus(1, 5'h08, 32'h8);
      bus(0, 5'h0c, 0);
      chk(rdv[4:3], 2'b11);
      bus(1, 5'h04, 32'h0000ff00 | 32'(s));
      bus(1, 5'h08, 32'h4);
      bus(0, 5'h10, 0);
      chk(rdv[15:8], 8'hff);
      wait_hi(core_reset_o, 40000);
      chk(s ? (nk > 32600 && nk < 32800) : (nk > 500 && nk < 520), 1);
      chk(reset_out_n_o, 0);
      config_port_i <= 16'h7777;
      wait_hi(restart_o, 3000);
      chk(config_latched_o, 16'hd701);
      config_port_i <= 16'h0ff0;
      bus(0, 5'h0c, 0);
      chk(rdv[2:0], 3);
    end
    test_done();
  end
endmodule // tb_rsw_reset_sequencer
bind rsw_reset_sequencer rsw_reset_sequencer_monitor #(.HOP_DIV(HOP_DIV)) u_mon (.ref_clk_i,
  .rst_n_i, .reset_in_n_i, .async_sel_i, .avs_write_i, .reset_in_n_o, .reset_in_n_oe_n_o,
  .reset_out_n_o, .core_reset_o, .hold_cancel_o, .io_tristate_o, .config_pullup_o,
  .restart_o, .restart_addr_o);
`default_nettype wire
